// *** logic/alarm_compare.v ***
// alarm comparators with shared hysteresis, updated per conversion pair
// assumes: results and limits are stable when conv_done pulses
`timescale 1ns/10ps
module alarm_compare (
  input wire sys_clk, // system clock
  input wire reset, // synchronous reset
  input wire conv_done, // one-cycle pulse after local and remote done
  input wire [7:0] local_whole, // local result, whole degrees signed
  input wire [7:0] remote_whole, // remote result, whole degrees
  input wire [7:0] local_limit, // shared local limit
  input wire [7:0] remote_crit, // remote critical limit
  input wire [7:0] remote_os, // remote overtemp limit
  input wire [7:0] hyst, // shared hysteresis
  output reg crit_active, // critical alarm asserted
  output reg os_active, // overtemp alarm asserted
  output reg local_limit_flag, // local above shared limit
  output reg remote_crit_flag, // remote above critical limit
  output reg remote_os_flag // remote above overtemp limit
);
  // negative readings never exceed an unsigned limit
  function above;
    input [8:0] val;
    input [8:0] lim;
    begin
      above = (val > lim); // [RL26]
    end
  endfunction
  function below_hyst;
    input [8:0] val;
    input [8:0] lim;
    input [7:0] h;
    begin
      below_hyst = ({1'b0, val} + {2'b00, h}) < {1'b0, lim};
    end
  endfunction
  wire [8:0] loc9 = local_whole[7] ? 9'h000 : {1'b0, local_whole};
  wire [8:0] rem9 = remote_whole[7] ? 9'h000 : {1'b0, remote_whole};
  wire loc_hi = above(loc9, {1'b0, local_limit});
  wire rc_hi = above(rem9, {1'b0, remote_crit});
  wire ro_hi = above(rem9, {1'b0, remote_os});
  wire crit_clear = below_hyst(loc9, {1'b0, local_limit}, hyst) &&
    below_hyst(rem9, {1'b0, remote_crit}, hyst); // [RL2]
  wire os_clear = below_hyst(loc9, {1'b0, local_limit}, hyst) &&
    below_hyst(rem9, {1'b0, remote_os}, hyst); // [RL25]
  always @(posedge sys_clk) begin
    if (reset) begin
      crit_active <= 1'b0;
      os_active <= 1'b0;
      local_limit_flag <= 1'b0;
      remote_crit_flag <= 1'b0;
      remote_os_flag <= 1'b0;
    end else if (conv_done) begin // [RL7]
      remote_crit_flag <= rc_hi; // [RL3]
      local_limit_flag <= loc_hi; // [RL4]
      remote_os_flag <= ro_hi; // [RL5]
      if (loc_hi || rc_hi)
        crit_active <= 1'b1; // [RL1]
      else if (crit_clear)
        crit_active <= 1'b0;
      if (loc_hi || ro_hi)
        os_active <= 1'b1; // [RL6]
      else if (os_clear)
        os_active <= 1'b0;
    end
  end
endmodule // alarm_compare

// *** logic/smbus_line_sync.v ***
// two-flop synchronisers and edge/condition detection for smbus lines
// assumes: smb_clk_in and smb_dat_in are asynchronous pins
`timescale 1ns/10ps
module smbus_line_sync (
  input wire sys_clk, // system clock
  input wire reset, // synchronous reset
  input wire smb_clk_in, // smbclk pin level
  input wire smb_dat_in, // smbdat pin level
  output reg scl, // synchronised clock level
  output reg sda, // synchronised data level
  output wire scl_rise, // one-cycle pulse
  output wire scl_fall, // one-cycle pulse
  output wire start_seen, // start or repeated start, pulse
  output wire stop_seen // stop condition, pulse
);
  reg scl_meta_reg;
  reg sda_meta_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  always @(posedge sys_clk) begin
    if (reset) begin
      scl_meta_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      scl <= 1'b1;
      sda <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= smb_clk_in;
      sda_meta_reg <= smb_dat_in;
      scl <= scl_meta_reg;
      sda <= sda_meta_reg;
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
    end
  end
  assign scl_rise = scl && !scl_prev_reg;
  assign scl_fall = !scl && scl_prev_reg;
  assign start_seen = scl && scl_prev_reg && sda_prev_reg && !sda;
  assign stop_seen = scl && scl_prev_reg && !sda_prev_reg && sda;
endmodule // smbus_line_sync

// *** logic/temp_alarm_regs.vh ***
// constants for the temperature alarm smbus slave
// assumes: included by temp_alarm_smbus_slave by its bare name
`ifndef TEMP_ALARM_REGS_VH
`define TEMP_ALARM_REGS_VH
`define PTR_RESET 8'h00
`define ADDR_LOCAL_MSB 8'h00
`define ADDR_REMOTE_MSB 8'h01
`define ADDR_STATUS1 8'h02
`define ADDR_CONFIG1_R 8'h03
`define ADDR_CONFIG1_W 8'h09
`define ADDR_ONE_SHOT 8'h0f
`define ADDR_REMOTE_LSB 8'h10
`define ADDR_REMOTE_OS 8'h0d
`define ADDR_REMOTE_OS_R 8'h07
`define ADDR_REMOTE_CRIT 8'h19
`define ADDR_LOCAL_LIMIT 8'h20
`define ADDR_HYST 8'h21
`define ADDR_LOCAL_LSB 8'h30
`define ADDR_REMOTE_UMSB 8'h31
`define ADDR_REMOTE_ULSB 8'h32
`define ADDR_CONFIG2 8'hbf
`define SLAVE_ADDR_HIGH 7'h4c
`define CONFIG1_RESET 8'h00
`define CONFIG2_RESET 8'h1f
`define REMOTE_OS_RESET 8'h55
`define LOCAL_LIMIT_RESET 8'h55
`define REMOTE_CRIT_RESET 8'h6e
`define HYST_RESET 8'h0a
`define CFG1_STANDBY_BIT 6
`define CFG2_OS_SEL_BIT 0
`define ST1_FAULT_BIT 2
`define ST1_LOC_BIT 0
`define ST1_ROS_BIT 3
`define ST1_RCRIT_BIT 4
`define ST1_CRIT_PIN_BIT 1
`define FAULT_SIGNED 11'h400
`define FAULT_UNSIGNED 11'h7ff
`define TIMEOUT_MS 35
`define CLK_HZ 25000000
`define TIMEOUT_CYCLES (`TIMEOUT_MS * (`CLK_HZ / 1000))
`endif

// *** logic/temp_alarm_smbus_slave.v ***
// smbus slave and alarm logic of a two-channel temperature sensor
// assumes: conversion results arrive with a one-cycle done pulse
// Overview of operation
// [RL1] critical output low when any result above limit
// [RL2] critical released when both below limit minus hysteresis
// [RL3] remote above critical limit sets its flag
// [RL4] local above shared limit sets its flag
// [RL5] remote above overtemp limit sets its flag
// [RL6] overtemp pin asserts when any result over limit
// [RL7] alarms and flags update only per conversion
// [RL8] diode fault forces fixed reading, sets bit two
// [RL9] pointer resets to local high byte
// [RL10] pointer holds until next command byte
// [RL11] master writes address, command, one data byte
// [RL12] address-only read returns pointed register
// [RL13] master reads other register via repeated start
// [RL14] data bytes shifted out msb first
// [RL15] ack or nack after read; nack ends
// [RL16] high byte read freezes matching low byte
// [RL17] bus idle after lines low over 35 ms
// [RL18] master holds line low 35 ms to reset
// [RL19] start anywhere restarts, expects address byte
// [RL20] one-shot write in standby runs one conversion
// [RL21] one-shot data discarded, reads back zero
// [RL22] pointer loaded from command byte in write
// [RL23] overtemp pin only with strap high, address 4ch
// [RL24] one-shot at 0x0f acts only in standby
// [RL25] overtemp released below limit minus hysteresis
// [RL26] comparisons are strictly greater than
`timescale 1ns/10ps
`include "temp_alarm_regs.vh"
module temp_alarm_smbus_slave #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input wire sys_clk, // system clock, 25 mhz
  input wire reset, // synchronous reset, active high
  input wire smb_clk_in, // smbclk pin level
  input wire smb_dat_in, // smbdat pin level
  output wire smb_dat_out, // smbdat drive value, always low
  output wire smb_dat_oe, // smbdat pull-low enable
  input wire [6:0] strap_address, // address from the strap pin level
  input wire address_strap, // strap pin reads high
  input wire conv_done, // pulse: local and remote conversion complete
  input wire [10:0] local_result, // local reading, left-justified 11 bits
  input wire [10:0] remote_result, // remote reading, signed 11 bits
  input wire diode_fault, // remote diode short or open
  output reg one_shot_req, // pulse: start one conversion cycle
  output wire standby, // conversions stopped
  output wire crit_alarm_n, // critical alarm, active low
  output wire overtemp_alarm_n, // overtemp output, active low
  output wire overtemp_oe // pin driven as overtemp output
);
  // one-hot slave states
  localparam S_IDLE = 6'b000001;
  localparam S_ADDR = 6'b000010;
  localparam S_RX = 6'b000100;
  localparam S_TX = 6'b001000;
  localparam S_ACK = 6'b010000;
  localparam S_MACK = 6'b100000;
  reg [5:0] state_reg;
  reg [7:0] register_pointer_reg;
  reg [7:0] config1_reg;
  reg [7:0] config2_reg;
  reg [7:0] remote_os_reg;
  reg [7:0] remote_crit_reg;
  reg [7:0] local_limit_reg;
  reg [7:0] hyst_reg;
  reg [10:0] local_reg;
  reg [10:0] remote_reg;
  reg [2:0] local_lsb_frz_reg;
  reg [2:0] remote_lsb_frz_reg;
  reg [2:0] uremote_lsb_frz_reg;
  reg local_lock_reg;
  reg remote_lock_reg;
  reg uremote_lock_reg;
  reg fault_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg read_dir_reg;
  reg first_byte_reg;
  reg ack_drive_reg;
  reg tx_drive_reg;
  reg [23:0] low_cnt_reg;
  wire scl;
  wire sda;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire crit_active;
  wire os_active;
  wire local_limit_flag;
  wire remote_crit_flag;
  wire remote_os_flag;
  // fault replaces the reading before it is stored or compared
  wire [10:0] remote_now = diode_fault ? `FAULT_SIGNED : remote_result;
  // pins pass two flops inside the line sync
  smbus_line_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .smb_clk_in(smb_clk_in),
    .smb_dat_in(smb_dat_in),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );
  alarm_compare u_cmp (
    .sys_clk(sys_clk),
    .reset(reset),
    .conv_done(conv_done),
    .local_whole(local_result[10:3]),
    .remote_whole(remote_now[10:3]),
    .local_limit(local_limit_reg),
    .remote_crit(remote_crit_reg),
    .remote_os(remote_os_reg),
    .hyst(hyst_reg),
    .crit_active(crit_active),
    .os_active(os_active),
    .local_limit_flag(local_limit_flag),
    .remote_crit_flag(remote_crit_flag),
    .remote_os_flag(remote_os_flag)
  );
  // the strap is not latched: address follows the pin while it is an input
  wire os_pin_mode = ~config2_reg[`CFG2_OS_SEL_BIT] & address_strap;
  wire [6:0] my_addr = os_pin_mode ? `SLAVE_ADDR_HIGH :
    strap_address; // [RL23]
  assign standby = config1_reg[`CFG1_STANDBY_BIT];
  assign crit_alarm_n = ~crit_active; // [RL1]
  assign overtemp_alarm_n = ~(os_active & os_pin_mode); // [RL6]
  assign overtemp_oe = os_pin_mode;
  // open drain: only the enable moves
  assign smb_dat_out = 1'b0;
  assign smb_dat_oe = ack_drive_reg | tx_drive_reg;
  // unsigned view: negative remote readings clip to zero, positive
  // readings keep their bit pattern
  wire [10:0] uremote = remote_reg[10] ? 11'h000 : remote_reg;
  wire [10:0] uremote_rpt = fault_reg ? `FAULT_UNSIGNED : uremote; // [RL8]
  // status bits 7..5 are unused and read zero
  wire [7:0] status1 = {3'b000, remote_crit_flag, remote_os_flag,
    fault_reg, ~crit_alarm_n, local_limit_flag};
  // undecoded locations read as zero
  function [7:0] read_mux;
    input [7:0] p;
    begin
      case (p)
        `ADDR_LOCAL_MSB: read_mux = local_reg[10:3];
        `ADDR_LOCAL_LSB: read_mux = {local_lsb_frz_reg, 5'h00};
        `ADDR_REMOTE_MSB: read_mux = remote_reg[10:3];
        `ADDR_REMOTE_LSB: read_mux = {remote_lsb_frz_reg, 5'h00};
        `ADDR_REMOTE_UMSB: read_mux = uremote_rpt[10:3];
        `ADDR_REMOTE_ULSB: read_mux = {uremote_lsb_frz_reg, 5'h00};
        `ADDR_STATUS1: read_mux = status1;
        `ADDR_CONFIG1_R: read_mux = config1_reg;
        `ADDR_CONFIG1_W: read_mux = config1_reg;
        `ADDR_CONFIG2: read_mux = config2_reg;
        `ADDR_REMOTE_OS: read_mux = remote_os_reg;
        `ADDR_REMOTE_OS_R: read_mux = remote_os_reg;
        `ADDR_REMOTE_CRIT: read_mux = remote_crit_reg;
        `ADDR_LOCAL_LIMIT: read_mux = local_limit_reg;
        `ADDR_HYST: read_mux = hyst_reg;
        default: read_mux = 8'h00; // one-shot reads zero [RL21]
      endcase
    end
  endfunction
  wire [7:0] tx_byte = read_mux(register_pointer_reg);
  // one count serves both lines; a low on either keeps it running, so
  // short lows on the two lines can add up (a known limitation)
  wire line_low = ~scl | ~sda;
  wire timeout = (low_cnt_reg >= TIMEOUT_CYCLES[23:0]);
  wire [7:0] rx_byte = {shift_reg[6:0], sda};
  // capture conversion results
  always @(posedge sys_clk) begin
    if (reset) begin
      local_reg <= 11'h000;
      remote_reg <= 11'h000;
      fault_reg <= 1'b0;
    end else if (conv_done) begin
      local_reg <= local_result;
      remote_reg <= remote_now; // [RL8]
      fault_reg <= diode_fault; // [RL8]
    end
  end
  always @(posedge sys_clk) begin
    if (reset)
      low_cnt_reg <= 24'h000000;
    else if (!line_low || state_reg == S_IDLE)
      low_cnt_reg <= 24'h000000;
    else if (!timeout)
      low_cnt_reg <= low_cnt_reg + 24'h000001;
  end
  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
      register_pointer_reg <= `PTR_RESET; // [RL9]
      config1_reg <= `CONFIG1_RESET;
      config2_reg <= `CONFIG2_RESET;
      remote_os_reg <= `REMOTE_OS_RESET;
      remote_crit_reg <= `REMOTE_CRIT_RESET;
      local_limit_reg <= `LOCAL_LIMIT_RESET;
      hyst_reg <= `HYST_RESET;
      local_lsb_frz_reg <= 3'b000;
      remote_lsb_frz_reg <= 3'b000;
      uremote_lsb_frz_reg <= 3'b000;
      local_lock_reg <= 1'b0;
      remote_lock_reg <= 1'b0;
      uremote_lock_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      read_dir_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      one_shot_req <= 1'b0;
    end else begin
      // the one-shot request lasts a single cycle
      one_shot_req <= 1'b0;
      // unlocked low bytes track the latest conversion
      if (!local_lock_reg)
        local_lsb_frz_reg <= local_reg[2:0];
      if (!remote_lock_reg)
        remote_lsb_frz_reg <= remote_reg[2:0];
      if (!uremote_lock_reg)
        uremote_lsb_frz_reg <= uremote_rpt[2:0];
      if (timeout) begin
        state_reg <= S_IDLE; // [RL17]
        ack_drive_reg <= 1'b0;
        tx_drive_reg <= 1'b0;
      end else if (start_seen) begin
        state_reg <= S_ADDR; // [RL19]
        bit_cnt_reg <= 4'h0;
        ack_drive_reg <= 1'b0;
        tx_drive_reg <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= S_IDLE;
        ack_drive_reg <= 1'b0;
        tx_drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            bit_cnt_reg <= 4'h0;
          end
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == S_ADDR) begin
                // a foreign address returns to idle, no ack
                if (shift_reg[7:1] == my_addr) begin
                  read_dir_reg <= shift_reg[0];
                  first_byte_reg <= 1'b1;
                  ack_drive_reg <= 1'b1;
                  state_reg <= S_ACK;
                end else
                  state_reg <= S_IDLE;
              end else begin
                ack_drive_reg <= 1'b1;
                state_reg <= S_ACK;
                if (first_byte_reg) begin
                  register_pointer_reg <= shift_reg; // [RL22] [RL10]
                  first_byte_reg <= 1'b0;
                end else begin
                  // one data byte goes to the held pointer [RL11]
                  case (register_pointer_reg)
                    `ADDR_CONFIG1_W: config1_reg <= shift_reg;
                    `ADDR_CONFIG1_R: config1_reg <= shift_reg;
                    `ADDR_CONFIG2: config2_reg <= shift_reg;
                    `ADDR_REMOTE_OS: remote_os_reg <= shift_reg;
                    `ADDR_REMOTE_OS_R: remote_os_reg <= shift_reg;
                    `ADDR_REMOTE_CRIT: remote_crit_reg <= shift_reg;
                    `ADDR_LOCAL_LIMIT: local_limit_reg <= shift_reg;
                    `ADDR_HYST: hyst_reg <= shift_reg;
                    // data is dropped, only the write counts [RL21]
                    `ADDR_ONE_SHOT: one_shot_req <= standby; // [RL20] [RL24]
                    default: ;
                  endcase
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              ack_drive_reg <= 1'b0;
              if (read_dir_reg) begin
                // pointer was set earlier; just return its byte [RL12]
                shift_reg <= tx_byte;
                // msb goes out now, at the fall that ends the ack [RL14]
                tx_drive_reg <= ~tx_byte[7];
                bit_cnt_reg <= 4'h1;
                state_reg <= S_TX;
                case (register_pointer_reg)
                  `ADDR_LOCAL_MSB: local_lock_reg <= 1'b1; // [RL16]
                  `ADDR_REMOTE_MSB: remote_lock_reg <= 1'b1; // [RL16]
                  `ADDR_REMOTE_UMSB: uremote_lock_reg <= 1'b1; // [RL16]
                  `ADDR_LOCAL_LSB: local_lock_reg <= 1'b0; // [RL16]
                  `ADDR_REMOTE_LSB: remote_lock_reg <= 1'b0; // [RL16]
                  `ADDR_REMOTE_ULSB: uremote_lock_reg <= 1'b0; // [RL16]
                  default: ;
                endcase
                if (register_pointer_reg == `ADDR_LOCAL_MSB)
                  local_lsb_frz_reg <= local_reg[2:0]; // [RL16]
                if (register_pointer_reg == `ADDR_REMOTE_MSB)
                  remote_lsb_frz_reg <= remote_reg[2:0]; // [RL16]
                if (register_pointer_reg == `ADDR_REMOTE_UMSB)
                  uremote_lsb_frz_reg <= uremote_rpt[2:0]; // [RL16]
              end else begin
                bit_cnt_reg <= 4'h0;
                state_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            // seven more bits, then release
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                tx_drive_reg <= 1'b0;
                state_reg <= S_MACK;
              end else begin
                tx_drive_reg <= ~shift_reg[7 - bit_cnt_reg[2:0]]; // [RL14]
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          S_MACK: begin
            // master ack repeats the byte; nack ends the read [RL15]
            if (scl_rise) begin
              if (sda)
                state_reg <= S_IDLE;
              else
                state_reg <= S_ACK;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule // temp_alarm_smbus_slave

// *** tb/smb_master.sv ***
// smbus master model: bus clock and open-drain data line
// assumes: data line pulled up; paced by the system clock
`timescale 1ns/10ps
module smb_master (
  input wire sys_clk, // pacing clock
  input wire dev_oe, // device pulls data low
  output reg scl, // bus clock line
  output wire sda // wired data line
);
  reg sda_drv;
  reg r;
  integer i;
  // pull-up wins only when both parties release
  assign sda = sda_drv & ~dev_oe;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // a quarter of the 320 ns bus clock; clock idles high between frames
  task q;
    repeat (2) @(posedge sys_clk);
  endtask
  task start; // also a repeated start
    q;
    sda_drv <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b0;
  endtask
  task stop;
    q;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_drv <= 1'b1;
    q;
  endtask
  // data changes mid low phase, sampled late in the high phase
  task bitx(input b, output o);
    q;
    sda_drv <= b;
    q;
    scl <= 1'b1;
    q;
    q;
    o = sda;
    scl <= 1'b0;
  endtask
  task wbyte(input [7:0] d, output ack);
    for (i = 7; i >= 0; i = i - 1)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task rbyte(input nack, output [7:0] d);
    for (i = 7; i >= 0; i = i - 1)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule // smb_master

// *** tb/tb_temp_alarm_smbus_slave.sv ***
// self-checking bench for the temperature alarm smbus slave
// assumes: smb_master drives the bus; conversions come from here
`timescale 1ns/10ps
module tb_temp_alarm_smbus_slave;
  localparam TO = 400;
  reg sys_clk, reset, conv_done, diode_fault, address_strap;
  reg [6:0] strap_address;
  reg [10:0] local_result, remote_result;
  reg [7:0] d;
  reg a;
  wire scl, sda, smb_dat_out, smb_dat_oe, one_shot_req, standby;
  wire crit_alarm_n, overtemp_alarm_n, overtemp_oe;
  integer n_fail = 0, comparisons = 0, cyc = 0, shots = 0;

  temp_alarm_smbus_slave #(.TIMEOUT_CYCLES(TO)) temp_alarm_smbus_slave_inst (
    .sys_clk(sys_clk), .reset(reset), .smb_clk_in(scl), .smb_dat_in(sda),
    .smb_dat_out(smb_dat_out), .smb_dat_oe(smb_dat_oe),
    .strap_address(strap_address), .address_strap(address_strap),
    .conv_done(conv_done), .local_result(local_result),
    .remote_result(remote_result), .diode_fault(diode_fault),
    .one_shot_req(one_shot_req), .standby(standby),
    .crit_alarm_n(crit_alarm_n), .overtemp_alarm_n(overtemp_alarm_n),
    .overtemp_oe(overtemp_oe));
  smb_master smb_master_inst (.sys_clk(sys_clk), .dev_oe(smb_dat_oe),
    .scl(scl), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (one_shot_req === 1'b1) shots <= shots + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input [7:0] exp, input [7:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task chkb(input string what, input exp, input got);
    chk(what, {7'h0, exp}, {7'h0, got});
  endtask
  task sa(input [7:0] b); // start, then the address byte
    smb_master_inst.start;
    smb_master_inst.wbyte(b, a);
  endtask
  task rdp; // read at the held pointer
    sa(8'h99);
    smb_master_inst.rbyte(1'b1, d);
    smb_master_inst.stop;
  endtask
  task rd(input [7:0] p);
    sa(8'h98);
    smb_master_inst.wbyte(p, a);
    rdp;
  endtask
  task wr(input [7:0] p, input [7:0] v);
    sa(8'h98);
    smb_master_inst.wbyte(p, a);
    smb_master_inst.wbyte(v, a);
    chkb("write ack", 1'b1, a);
    smb_master_inst.stop;
  endtask
  // whole degrees for local; remote with three fraction bits
  task conv(input [7:0] l, input [7:0] r, input [2:0] rf, input f);
    local_result <= {l, 3'h0};
    remote_result <= {r, rf};
    diode_fault <= f;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    reset <= 1'b1;
    conv_done <= 1'b0;
    diode_fault <= 1'b0;
    local_result <= 11'h0;
    remote_result <= 11'h0;
    address_strap <= 1'b1;
    strap_address <= 7'h4c;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    conv(8'd25, 8'd30, 3'h0, 1'b0);
    rdp;
    chk("local msb", 8'h19, d);
    wr(8'h20, 8'h14);
    wr(8'hbf, 8'h1e);
    chkb("crit early", 1'b1, crit_alarm_n);
    chkb("os mode", 1'b1, overtemp_oe);
    chkb("dat low", 1'b0, smb_dat_out);
    conv(8'd25, 8'd110, 3'h0, 1'b0);
    chkb("crit set", 1'b0, crit_alarm_n);
    chkb("os set", 1'b0, overtemp_alarm_n);
    rd(8'h02);
    chk("status a", 8'h09, d & 8'h19);
    conv(8'd15, 8'd111, 3'h0, 1'b0);
    rd(8'h02);
    chk("status b", 8'h18, d & 8'h19);
    conv(8'd15, 8'd105, 3'h0, 1'b0);
    chkb("crit held", 1'b0, crit_alarm_n);
    conv(8'd9, 8'd99, 3'h0, 1'b0);
    chkb("crit free", 1'b1, crit_alarm_n);
    chkb("os held", 1'b0, overtemp_alarm_n);
    conv(8'd9, 8'd70, 3'h0, 1'b0);
    chkb("os free", 1'b1, overtemp_alarm_n);
    conv(8'd9, 8'd70, 3'h0, 1'b1);
    rd(8'h01);
    chk("fault signed", 8'h80, d);
    rd(8'h31);
    chk("fault unsigned", 8'hff, d);
    rd(8'h02);
    chk("fault bit", 8'h04, d & 8'h04);
    conv(8'd9, 8'd30, 3'h5, 1'b0);
    rd(8'h01);
    chk("remote msb", 8'h1e, d);
    rd(8'h31);
    chk("remote umsb", 8'h1e, d);
    conv(8'd9, 8'd30, 3'h2, 1'b0);
    rd(8'h10);
    chk("locked lsb", 8'ha0, d);
    rdp;
    chk("free lsb", 8'h40, d);
    wr(8'h0f, 8'ha5);
    chk("shot awake", 8'h00, shots[7:0]);
    wr(8'h09, 8'h40);
    chkb("standby", 1'b1, standby);
    wr(8'h0f, 8'ha5);
    chk("shot count", 8'h01, shots[7:0]);
    rd(8'h0f);
    chk("shot read", 8'h00, d);
    sa(8'h99);
    smb_master_inst.rbyte(1'b0, d);
    chk("acked byte", 8'h00, d);
    smb_master_inst.rbyte(1'b1, d);
    chk("last byte", 8'h00, d);
    smb_master_inst.stop;
    sa(8'h30);
    chkb("foreign addr", 1'b0, a);
    smb_master_inst.stop;
    sa(8'h99);
    repeat (8) @(posedge sys_clk);
    chkb("bit held", 1'b1, smb_dat_oe);
    repeat (TO + 20) @(posedge sys_clk);
    chkb("timed out", 1'b0, smb_dat_oe);
    rd(8'h01);
    chk("after timeout", 8'h1e, d);
    sa(8'h98);
    repeat (3) smb_master_inst.bitx(1'b0, a);
    sa(8'h99);
    chkb("restart ack", 1'b1, a);
    smb_master_inst.rbyte(1'b1, d);
    smb_master_inst.stop;
    chk("restart read", 8'h1e, d);
    conclude;
  end
endmodule // tb_temp_alarm_smbus_slave

// *** tb/temp_alarm_chk.sv ***
// assertion checker for the temperature alarm smbus slave
// assumes: bound to the top module, one clock domain
`timescale 1ns/10ps
module temp_alarm_chk #(
  parameter TIMEOUT_CYCLES = 875000
) (
  input wire sys_clk, // system clock
  input wire reset, // sync reset
  input wire smb_clk_in, // bus clock pin
  input wire smb_dat_oe, // data pull-low enable
  input wire address_strap, // strap high
  input wire conv_done, // conversion pulse
  input wire one_shot_req, // one-shot pulse
  input wire standby, // standby level
  input wire crit_alarm_n, // critical alarm
  input wire overtemp_alarm_n, // overtemp alarm
  input wire overtemp_oe // overtemp pin mode
);
  reg [31:0] low_cnt;
  // cycles the bus clock pin has been low, saturating
  always @(posedge sys_clk) begin
    if (reset || smb_clk_in)
      low_cnt <= 32'h0;
    else if (low_cnt != 32'hffffffff)
      low_cnt <= low_cnt + 32'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_rst_out;
    $fell(reset) |-> crit_alarm_n && overtemp_alarm_n && !smb_dat_oe
      && !standby && !one_shot_req;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");
  property p_crit_hold;
    $changed(crit_alarm_n) |-> $past(conv_done);
  endproperty
  a_crit_hold: assert property (p_crit_hold)
    else $error("critical alarm moved between conversions");
  property p_os_hold;
    overtemp_oe && $past(overtemp_oe) && $changed(overtemp_alarm_n)
      |-> $past(conv_done);
  endproperty
  a_os_hold: assert property (p_os_hold)
    else $error("overtemp alarm moved between conversions");
  property p_os_idle;
    !overtemp_oe |-> overtemp_alarm_n;
  endproperty
  a_os_idle: assert property (p_os_idle)
    else $error("overtemp asserted while pin is address input");
  property p_strap;
    overtemp_oe |-> address_strap;
  endproperty
  a_strap: assert property (p_strap)
    else $error("overtemp mode without strap high");
  property p_pulse;
    one_shot_req |=> !one_shot_req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("one-shot request longer than a cycle");
  property p_shot_stby;
    one_shot_req |-> standby;
  endproperty
  a_shot_stby: assert property (p_shot_stby)
    else $error("one-shot request outside standby");
  property p_dat_on_low;
    $changed(smb_dat_oe) |-> !smb_clk_in;
  endproperty
  a_dat_on_low: assert property (p_dat_on_low)
    else $error("data line changed while bus clock high");
  property p_timeout;
    (low_cnt == TIMEOUT_CYCLES + 8) |-> !smb_dat_oe;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("data line still held after bus timeout");
  c_conv: cover property (conv_done);
  c_shot: cover property (one_shot_req);
  c_crit: cover property ($fell(crit_alarm_n));
endmodule // temp_alarm_chk

bind temp_alarm_smbus_slave temp_alarm_chk #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) temp_alarm_chk_inst (
  .sys_clk(sys_clk),
  .reset(reset),
  .smb_clk_in(smb_clk_in),
  .smb_dat_oe(smb_dat_oe),
  .address_strap(address_strap),
  .conv_done(conv_done),
  .one_shot_req(one_shot_req),
  .standby(standby),
  .crit_alarm_n(crit_alarm_n),
  .overtemp_alarm_n(overtemp_alarm_n),
  .overtemp_oe(overtemp_oe)
);
